// [bench/dpram_props.sv]
// Concurrent checks on the ports of the RAM and FIFO block.
`timescale 1ns/1ns
`include "dpram_cfg.svh"
module dpram_props (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [7:0]  araddr,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic        full_flag,
   input wire logic        empty_flag,
   input wire logic        almost_full_flag,
   input wire logic        almost_empty_flag
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   ar_to_r_a: assert property (arvalid && arready |=> !rvalid ##1 rvalid)
      else $error("read answer not two cycles after address");
   r_stand_a: assert property (rvalid && !rready |=>
      rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer changed before handshake");
   b_stand_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response changed before handshake");
   ar_block_a: assert property (rvalid |-> !arready)
      else $error("read address accepted while answer pending");
   aw_drop_a: assert property (awvalid && awready |=> !awready)
      else $error("write address ready stayed high after transfer");
   wr_resp_a: assert property (awvalid && awready && wvalid && wready
      |-> ##2 bvalid)
      else $error("write response late");
   bad_addr_a: assert property (arvalid && arready && araddr > `OFF_THRESH
      |-> ##2 rresp == 2'b10 && rdata == 32'h0)
      else $error("unmapped read not refused");
   rst_state_a: assert property (disable iff (1'b0) !aresetn |=>
      empty_flag && almost_empty_flag && !full_flag && !almost_full_flag
      && !bvalid && !rvalid)
      else $error("state not cleared by reset");
   flag_excl_a: assert property (!(full_flag && empty_flag))
      else $error("full and empty together");

   cover property (rvalid && rready && rresp == 2'b10);
   cover property ($rose(full_flag));
   cover property ($rose(almost_full_flag));
endmodule : dpram_props

bind dual_port_ram_fifo_block dpram_props props_u (.aclk, .aresetn, .awvalid,
   .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
   .arready, .rdata, .rresp, .rvalid, .rready, .full_flag, .empty_flag,
   .almost_full_flag, .almost_empty_flag);

// [bench/dual_port_ram_fifo_block_tb_top.sv]
// Register-level tests of the RAM and FIFO block.
`timescale 1ns/1ns
`include "dpram_cfg.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
   $display("Error at %0t: got %h expected %h", $time, a, b); end end
module dual_port_ram_fifo_block_tb_top;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic full_flag, empty_flag, almost_full_flag, almost_empty_flag;
   int n_errors = 0, checks_done = 0, cycles = 0, w;

   always #2 aclk = ~aclk;

   fabric_master fabric_u (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready);

   dual_port_ram_fifo_block dut_u (.aclk, .aresetn, .awaddr,
      .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .full_flag, .empty_flag,
      .almost_full_flag, .almost_empty_flag);

   task automatic end_sim();
      $display("Checks %0d, errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim

   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      fabric_u.wr(a, v, 4'hf, rs);
      `CHK(rs, 2'b00)
   endtask : wreg

   task automatic rreg(input logic [7:0] a, input logic [31:0] e);
      fabric_u.rd(a, d, rs);
      `CHK(d, e)
   endtask : rreg

   // Port command: data in [30:13], write in [12], item address in [11:0].
   task automatic cmd(input logic [7:0] p, input logic [11:0] a,
                      input logic we, input logic [17:0] v);
      wreg(p, {1'b0, v, we, a});
   endtask : cmd

   always @(posedge aclk) begin
      cycles++;
      if (cycles == 30000) begin
         n_errors++;
         $display("Error at %0t: run did not finish", $time);
         end_sim();
      end
   end

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rreg(`OFF_STATUS, 32'h0000000a);
      rreg(`OFF_CTRL, 32'h0);
      rreg(`OFF_THRESH, 32'h00400e00);
      fabric_u.rd(8'h24, d, rs);
      `CHK({rs, d}, {2'b10, 32'h0})
      fabric_u.wr(8'h24, 32'h1, 4'hf, rs);
      `CHK(rs, 2'b10)
      fabric_u.wr(`OFF_CTRL, 32'h1, 4'h1, rs);
      rreg(`OFF_CTRL, 32'h0);
      // Nine-bit port A with write pass-through, then with hold.
      wreg(`OFF_CTRL, 32'h206);
      cmd(`OFF_PORT_A, 12'd3, 1'b1, 18'h0b6);
      fabric_u.rd(`OFF_DOUT_A, d, rs);
      `CHK(d[8:0], 9'h0b6)
      wreg(`OFF_CTRL, 32'h006);
      cmd(`OFF_PORT_A, 12'd4, 1'b1, 18'h1ff);
      fabric_u.rd(`OFF_DOUT_A, d, rs);
      `CHK(d[8:0], 9'h0b6)
      // Read word 3 through port B at every width code, item 1 of the word below code 11, the whole word at 11.
      for (int c = 0; c < 4; c++) begin
         w = 1 << c;
         wreg(`OFF_CTRL, 32'h106 | (c << 3));
         cmd(`OFF_PORT_B, (c < 3) ? 12'(3 * (8 >> c) + 1) : 12'd3, 1'b0,
             18'h0);
         fabric_u.rd(`OFF_DOUT_B, d, rs);
         if (c < 3)
            `CHK(d[3:0] & 4'((1 << w) - 1), 4'((9'h0b6 >> w) & ((1 << w) - 1)))
         else
            `CHK(d[8:0], 9'h0b6)
      end
      // A write while frozen leaves the word unchanged.
      wreg(`OFF_CTRL, 32'h806);
      cmd(`OFF_PORT_A, 12'd3, 1'b1, 18'h055);
      wreg(`OFF_CTRL, 32'h006);
      cmd(`OFF_PORT_A, 12'd3, 1'b0, 18'h0);
      fabric_u.rd(`OFF_DOUT_A, d, rs);
      `CHK(d[8:0], 9'h0b6)
      // Port B writes 18 bits at item 5 with pass-through; port A reads
      // the upper half back as nine-bit word 11 through its pipeline.
      wreg(`OFF_CTRL, 32'h4c6);
      cmd(`OFF_PORT_B, 12'd5, 1'b1, 18'h2a5c3);
      fabric_u.rd(`OFF_DOUT_B, d, rs);
      `CHK(d[17:0], 18'h2a5c3)
      cmd(`OFF_PORT_A, 12'd11, 1'b0, 18'h0);
      fabric_u.rd(`OFF_DOUT_A, d, rs);
      `CHK(d[8:0], 9'(18'h2a5c3 >> 9))
      // FIFO of 512 nine-bit items, almost full at 4, almost empty at 1.
      wreg(`OFF_THRESH, 32'h00010004);
      wreg(`OFF_CTRL, 32'h007);
      for (int i = 0; i < 512; i++) begin
         wreg(`OFF_FIFO_WR, 32'(9'(i) ^ 9'h155));
         if (i == 2) begin
            repeat (4) @(posedge aclk);
            rreg(`OFF_STATUS, 32'h00000030);
         end
      end
      repeat (4) @(posedge aclk);
      rreg(`OFF_STATUS, 32'h00002005);
      wreg(`OFF_FIFO_WR, 32'h0aa);
      repeat (4) @(posedge aclk);
      rreg(`OFF_STATUS, 32'h00002005);
      for (int i = 0; i < 512; i++) begin
         wreg(`OFF_FIFO_RD, 32'h0);
         fabric_u.rd(`OFF_DOUT_B, d, rs);
         `CHK(d[8:0], 9'(i) ^ 9'h155)
      end
      wreg(`OFF_FIFO_RD, 32'h0);
      repeat (4) @(posedge aclk);
      rreg(`OFF_STATUS, 32'h0000000a);
      end_sim();
   end
endmodule : dual_port_ram_fifo_block_tb_top

// [bench/fabric_master.sv]
// Register bus master standing in for the user fabric logic.
`timescale 1ns/1ns
module fabric_master (
   input  wire logic        aclk,
   output logic [7:0]       awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   output logic [7:0]       araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [1:0] r);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) break;
      end
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
endmodule : fabric_master

// [core/dual_port_ram_fifo_block.sv]
// Dual-port RAM and FIFO block with an AXI4-Lite register front end.
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "dpram_cfg.svh"
// Contract
// - Every read and write is sampled on a clock edge.
// - Both ports run independently at up to 250 MHz; here both ports share the one clock aclk.
// - Dual-port organisations 4kx1, 2kx2, 1kx4, 512x9, two accesses per cycle; the register front end issues at most one port access per register write.
// - Two-port organisations 512x9 and 256x18 with one reader, one writer.
// - Writes synchronous; reads synchronous, pipelined or not.
// - Built-in FIFO controller makes addresses and four flags.
// - Same-address read/write or write/write on both ports is allowed.
// - RAM mode uses user addresses and ignores the FIFO controller.
// - FIFO mode routes controller addresses to the array.
// - Write and read widths are selected independently; in FIFO mode the code reads at port A's width.
// - Widths of one, two or four leave the ninth bit unused.
// - Nine-bit writes read as four bits expose only two nibbles.
// - Four-bit writes read as nine bits leave the ninth bit undefined.
// - Narrow items map little-endian into wider words.
// - The array holds 4,608 bits as 512 nine-bit words.
// - Freeze keeps memory and FIFO state intact.
// - Width code 00 4kx1, 01 2kx2, 10 1kx4, 11 512x9; static.
// - Pipeline select low gives data same cycle, high one later.
// - On write the output holds, or passes write data when mode high.
// - Reset clears control and output registers, blocks access, keeps array.
module dual_port_ram_fifo_block (
   input  logic        aclk,
   input  logic        aresetn,
   input  logic [7:0]  awaddr,
   input  logic [2:0]  awprot,
   input  logic        awvalid,
   output logic        awready,
   input  logic [31:0] wdata,
   input  logic [3:0]  wstrb,
   input  logic        wvalid,
   output logic        wready,
   output logic [1:0]  bresp,
   output logic        bvalid,
   input  logic        bready,
   input  logic [7:0]  araddr,
   input  logic [2:0]  arprot,
   input  logic        arvalid,
   output logic        arready,
   output logic [31:0] rdata,
   output logic [1:0]  rresp,
   output logic        rvalid,
   input  logic        rready,
   output logic        full_flag,
   output logic        empty_flag,
   output logic        almost_full_flag,
   output logic        almost_empty_flag
);
   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [11:0]       ctrl_reg;
   logic [12:0]       af_thr_reg;
   logic [12:0]       ae_thr_reg;
   logic              aw_got_reg;
   logic              w_got_reg;
   logic [7:0]        awaddr_reg;
   logic [31:0]       wdata_reg;
   logic [3:0]        wstrb_reg;
   logic              ar_pend_reg;
   logic [7:0]        araddr_reg;
   logic [12:0]       wr_ptr_reg;
   logic [12:0]       rd_ptr_reg;
   logic [12:0]       wr_gray_reg;
   logic [12:0]       rd_gray_reg;
   logic [12:0]       level_reg;
   logic              aw_hs;
   logic              w_hs;
   logic              ar_hs;
   logic              do_wr;
   logic              wr_hit;
   logic              cmd_ok;
   logic              fifo_on;
   logic              ram_a;
   logic              ram_b;
   logic              push;
   logic              pop;
   logic              full_now;
   logic              empty_now;
   logic              aw_got_next;
   logic              w_got_next;
   logic              rvalid_next;
   logic [12:0]       depth;
   logic [12:0]       wr_level;
   logic [12:0]       rd_level;
   logic [12:0]       wr_addr;
   logic [12:0]       rd_addr;
   logic [31:0]       rd_mux;
   logic              rd_err;
   dpram_pkg::width_t width_a;
   dpram_pkg::width_t width_b;

   mem_port_if mp ();

   mem_array_core u_core (
      .aclk    (aclk),
      .aresetn (aresetn),
      .mp      (mp)
   );

   function automatic logic [12:0] gray2bin(input logic [12:0] g);
      logic [12:0] b;
      b[12] = g[12];
      for (int i = 11; i >= 0; i--) begin
         b[i] = b[i + 1] ^ g[i];
      end
      return b;
   endfunction : gray2bin

   function automatic dpram_pkg::width_t to_width(input logic [1:0] code,
                                                  input logic       wide);
      return wide ? dpram_pkg::wd18 : dpram_pkg::width_t'({1'b0, code});
   endfunction : to_width

   function automatic logic [12:0] depth_of(input dpram_pkg::width_t w);
      logic [12:0] d;
      case (w)
         dpram_pkg::wd1: d = `DEPTH_W1;
         dpram_pkg::wd2: d = `DEPTH_W2;
         dpram_pkg::wd4: d = `DEPTH_W4;
         dpram_pkg::wd9: d = `DEPTH_W9;
         default:        d = `DEPTH_W18;
      endcase
      return d;
   endfunction : depth_of

   // ------------------------------------------------------------
   // Decode and FIFO arithmetic
   // ------------------------------------------------------------
   assign aw_hs   = awvalid & awready;
   assign w_hs    = wvalid & wready;
   assign ar_hs   = arvalid & arready;
   assign do_wr   = aw_got_reg & w_got_reg & ~bvalid;
   assign wr_hit  = awaddr_reg inside {`OFF_CTRL, `OFF_PORT_A, `OFF_PORT_B,
                    `OFF_DOUT_A, `OFF_DOUT_B, `OFF_FIFO_WR, `OFF_FIFO_RD,
                    `OFF_STATUS, `OFF_THRESH};
   // Freeze stops every access so array and pointers stay as they are.
   assign cmd_ok  = do_wr & (wstrb_reg == 4'hf)
                    & ~ctrl_reg[`CTRL_FRZ];
   assign fifo_on = ctrl_reg[`CTRL_FIFO];
   assign ram_a   = cmd_ok & ~fifo_on
                    & (awaddr_reg == `OFF_PORT_A);
   assign ram_b   = cmd_ok & ~fifo_on & (awaddr_reg == `OFF_PORT_B);

   assign width_a = to_width(ctrl_reg[`CTRL_WA +: 2],
                             ctrl_reg[`CTRL_A18]);
   assign width_b = fifo_on ? width_a
                    : to_width(ctrl_reg[`CTRL_WB +: 2],
                               ctrl_reg[`CTRL_B18]);
   assign depth   = depth_of(width_a);

   // Each side compares its own pointer with the other side's pointer
   // recovered from a registered Gray copy; the stale view only makes
   // the FIFO look fuller or emptier than it is.
   assign wr_level  = wr_ptr_reg - gray2bin(rd_gray_reg);
   assign rd_level  = gray2bin(wr_gray_reg) - rd_ptr_reg;
   assign full_now  = wr_level >= depth;
   assign empty_now = rd_level == 13'h0;
   assign push      = cmd_ok & fifo_on & ~full_now
                      & (awaddr_reg == `OFF_FIFO_WR);
   assign pop       = cmd_ok & fifo_on & ~empty_now
                      & (awaddr_reg == `OFF_FIFO_RD);
   assign wr_addr   = wr_ptr_reg & (depth - 13'h1);
   assign rd_addr   = rd_ptr_reg & (depth - 13'h1);

   assign aw_got_next = ~do_wr & (aw_got_reg | aw_hs);
   assign w_got_next  = ~do_wr & (w_got_reg | w_hs);
   assign rvalid_next = ar_pend_reg | (rvalid & ~rready);

   // ------------------------------------------------------------
   // Memory port drive
   // ------------------------------------------------------------
   assign mp.width[0] = width_a;
   assign mp.width[1] = width_b;
   assign mp.pipe     = {ctrl_reg[`CTRL_PB], ctrl_reg[`CTRL_PA]};
   assign mp.wmode    = {ctrl_reg[`CTRL_MB], ctrl_reg[`CTRL_MA]};

   // Ports A and B have separate branches, but one register write issues at most one of them.
   always_ff @(posedge aclk) begin : port_drive
      if (!aresetn) begin
         mp.en       <= 2'b00;
         mp.we       <= 2'b00;
         mp.addr[0]  <= 12'h000;
         mp.addr[1]  <= 12'h000;
         mp.wdata[0] <= 18'h0;
         mp.wdata[1] <= 18'h0;
      end else begin
         mp.en <= 2'b00;
         if (ram_a || push) begin
            mp.en[0]    <= 1'b1;
            mp.we[0]    <= push | wdata_reg[`CMD_WE];
            mp.addr[0]  <= push ? wr_addr[11:0]
                           : wdata_reg[`CMD_ADDR +: 12];
            mp.wdata[0] <= push ? wdata_reg[17:0]
                           : wdata_reg[`CMD_DATA +: 18];
         end
         if (ram_b || pop) begin
            mp.en[1]    <= 1'b1;
            mp.we[1]    <= ram_b & wdata_reg[`CMD_WE];
            mp.addr[1]  <= pop ? rd_addr[11:0]
                           : wdata_reg[`CMD_ADDR +: 12];
            mp.wdata[1] <= wdata_reg[`CMD_DATA +: 18];
         end
      end
   end

   // ------------------------------------------------------------
   // FIFO pointers and flags
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin : fifo_ptrs
      if (!aresetn) begin
         wr_ptr_reg  <= 13'h0;
         rd_ptr_reg  <= 13'h0;
         wr_gray_reg <= 13'h0;
         rd_gray_reg <= 13'h0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 13'h1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 13'h1;
         end
         wr_gray_reg <= wr_ptr_reg ^ (wr_ptr_reg >> 1);
         rd_gray_reg <= rd_ptr_reg ^ (rd_ptr_reg >> 1);
      end
   end

   always_ff @(posedge aclk) begin : fifo_flags
      if (!aresetn) begin
         full_flag         <= 1'b0;
         empty_flag        <= 1'b1;
         almost_full_flag  <= 1'b0;
         almost_empty_flag <= 1'b1;
         level_reg         <= 13'h0;
      end else begin
         full_flag         <= full_now;
         empty_flag        <= empty_now;
         almost_full_flag  <= wr_level >= af_thr_reg;
         almost_empty_flag <= rd_level <= ae_thr_reg;
         level_reg         <= wr_level;
      end
   end

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin : cfg_regs
      if (!aresetn) begin
         ctrl_reg   <= `CTRL_RST;
         af_thr_reg <= `AF_THR_RST;
         ae_thr_reg <= `AE_THR_RST;
      end else if (do_wr && wstrb_reg == 4'hf) begin
         if (awaddr_reg == `OFF_CTRL) begin
            ctrl_reg <= wdata_reg[11:0];
         end
         if (awaddr_reg == `OFF_THRESH) begin
            af_thr_reg <= wdata_reg[12:0];
            ae_thr_reg <= wdata_reg[`THR_AE +: 13];
         end
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite write and read channels
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin : wr_chan
      if (!aresetn) begin
         aw_got_reg <= 1'b0;
         w_got_reg  <= 1'b0;
         awready    <= 1'b0;
         wready     <= 1'b0;
         bvalid     <= 1'b0;
         bresp      <= `RESP_OKAY;
         awaddr_reg <= 8'h00;
         wdata_reg  <= 32'h0;
         wstrb_reg  <= 4'h0;
      end else begin
         aw_got_reg <= aw_got_next;
         w_got_reg  <= w_got_next;
         awready    <= ~aw_got_next;
         wready     <= ~w_got_next;
         if (aw_hs) begin
            awaddr_reg <= awaddr;
         end
         if (w_hs) begin
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
         end
         if (do_wr) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_mux = 32'h0;
      rd_err = 1'b0;
      case (araddr_reg)
         `OFF_CTRL:   rd_mux = {20'h0, ctrl_reg};
         `OFF_DOUT_A: rd_mux = {14'h0, mp.dout[0]};
         `OFF_DOUT_B: rd_mux = {14'h0, mp.dout[1]};
         `OFF_STATUS: rd_mux = {15'h0, level_reg, almost_empty_flag,
                                almost_full_flag, empty_flag, full_flag};
         `OFF_THRESH: rd_mux = {3'h0, ae_thr_reg, 3'h0, af_thr_reg};
         `OFF_PORT_A, `OFF_PORT_B, `OFF_FIFO_WR, `OFF_FIFO_RD:
            rd_mux = 32'h0;
         default:     rd_err = 1'b1;
      endcase
   end

   // Data is sampled one cycle after the address so a pipelined output
   // stage has settled before it is returned.
   always_ff @(posedge aclk) begin : rd_chan
      if (!aresetn) begin
         ar_pend_reg <= 1'b0;
         araddr_reg  <= 8'h00;
         arready     <= 1'b0;
         rvalid      <= 1'b0;
         rdata       <= 32'h0;
         rresp       <= `RESP_OKAY;
      end else begin
         ar_pend_reg <= ar_hs;
         arready     <= ~(ar_hs | rvalid_next);
         rvalid      <= rvalid_next;
         if (ar_hs) begin
            araddr_reg <= araddr;
         end
         if (ar_pend_reg) begin
            rdata <= rd_mux;
            rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
         end
      end
   end
endmodule : dual_port_ram_fifo_block

// [core/mem_array_core.sv]
// Storage array of 512 nine-bit words with two width-mapped ports.
`timescale 1ns/1ns
module mem_array_core (
   input  wire logic aclk,
   input  wire logic aresetn,
   mem_port_if.core  mp
);
   logic [8:0] mem [512];

   // ------------------------------------------------------------
   // Array writes
   // ------------------------------------------------------------
   // Narrow items pack little-endian; the ninth bit is left alone.
   always_ff @(posedge aclk) begin : store
      for (int p = 0; p < 2; p++) begin
         if (aresetn && mp.en[p] && mp.we[p]) begin
            case (mp.width[p])
               dpram_pkg::wd1:
                  mem[mp.addr[p][11:3]][mp.addr[p][2:0]]
                     <= mp.wdata[p][0];
               dpram_pkg::wd2:
                  mem[mp.addr[p][10:2]][{mp.addr[p][1:0], 1'b0} +: 2]
                     <= mp.wdata[p][1:0];
               dpram_pkg::wd4:
                  mem[mp.addr[p][9:1]][{mp.addr[p][0], 2'b00} +: 4]
                     <= mp.wdata[p][3:0];
               dpram_pkg::wd9:
                  mem[mp.addr[p][8:0]] <= mp.wdata[p][8:0];
               default: begin
                  mem[{mp.addr[p][7:0], 1'b0}] <= mp.wdata[p][8:0];
                  mem[{mp.addr[p][7:0], 1'b1}] <= mp.wdata[p][17:9];
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Read paths and output registers
   // ------------------------------------------------------------
   for (genvar p = 0; p < 2; p++) begin : g_port
      logic [17:0] rd_word;
      logic [17:0] s1_reg;
      logic [17:0] s2_reg;

      // Reads see the array before a same-edge write lands.
      always_comb begin
         case (mp.width[p])
            dpram_pkg::wd1:
               rd_word = {17'h0, mem[mp.addr[p][11:3]][mp.addr[p][2:0]]};
            dpram_pkg::wd2:
               rd_word = {16'h0, mem[mp.addr[p][10:2]]
                          [{mp.addr[p][1:0], 1'b0} +: 2]};
            dpram_pkg::wd4:
               rd_word = {14'h0, mem[mp.addr[p][9:1]]
                          [{mp.addr[p][0], 2'b00} +: 4]};
            dpram_pkg::wd9:
               rd_word = {9'h0, mem[mp.addr[p][8:0]]};
            default:
               rd_word = {mem[{mp.addr[p][7:0], 1'b1}],
                          mem[{mp.addr[p][7:0], 1'b0}]};
         endcase
      end

      always_ff @(posedge aclk) begin : hold
         if (!aresetn) begin
            s1_reg <= 18'h0;
         end else if (mp.en[p]) begin
            if (!mp.we[p]) begin
               s1_reg <= rd_word;
            end else if (mp.wmode[p]) begin
               s1_reg <= mp.wdata[p];
            end
         end
      end

      always_ff @(posedge aclk) begin : pipe_stage
         if (!aresetn) begin
            s2_reg <= 18'h0;
         end else begin
            s2_reg <= s1_reg;
         end
      end

      assign mp.dout[p] = mp.pipe[p] ? s2_reg : s1_reg;
   end
endmodule : mem_array_core

// [include/dpram_cfg.svh]
// Register map, field positions, reset values and depths of the RAM block.
`ifndef DPRAM_CFG_SVH
`define DPRAM_CFG_SVH
`define OFF_CTRL     8'h00
`define OFF_PORT_A   8'h04
`define OFF_PORT_B   8'h08
`define OFF_DOUT_A   8'h0c
`define OFF_DOUT_B   8'h10
`define OFF_FIFO_WR  8'h14
`define OFF_FIFO_RD  8'h18
`define OFF_STATUS   8'h1c
`define OFF_THRESH   8'h20
`define CTRL_FIFO    0
`define CTRL_WA      1
`define CTRL_WB      3
`define CTRL_A18     5
`define CTRL_B18     6
`define CTRL_PA      7
`define CTRL_PB      8
`define CTRL_MA      9
`define CTRL_MB      10
`define CTRL_FRZ     11
`define CMD_ADDR     0
`define CMD_WE       12
`define CMD_DATA     13
`define THR_AE       16
`define CTRL_RST     12'h000
`define AF_THR_RST   13'h0e00
`define AE_THR_RST   13'h0040
`define DEPTH_W1     13'h1000
`define DEPTH_W2     13'h0800
`define DEPTH_W4     13'h0400
`define DEPTH_W9     13'h0200
`define DEPTH_W18    13'h0100
`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10
`endif

// [include/dpram_pkg.sv]
// Types shared by the RAM block modules.
package dpram_pkg;
   typedef enum logic [2:0] {wd1, wd2, wd4, wd9, wd18} width_t;
endpackage : dpram_pkg

// [include/mem_port_if.sv]
// Two memory ports between the block controller and the storage array.
`timescale 1ns/1ns
interface mem_port_if;
   logic [1:0]        en;
   logic [1:0]        we;
   logic [11:0]       addr  [2];
   logic [17:0]       wdata [2];
   logic [17:0]       dout  [2];
   dpram_pkg::width_t width [2];
   logic [1:0]        pipe;
   logic [1:0]        wmode;
   modport ctrl (output en, we, addr, wdata, width, pipe, wmode,
                 input dout);
   modport core (input en, we, addr, wdata, width, pipe, wmode,
                 output dout);
endinterface : mem_port_if
